// ### design/dfs_pkg.sv
// package: constants, offsets and types of the drive fault supervisor
package dfs_pkg;
	localparam int          DFS_ADDR_W       = 6;
	localparam int          DFS_TEMP_W       = 12;
	localparam int          DFS_VOLT_W       = 12;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0]  DFS_OFF_STATUS   = 6'h00;
	localparam logic [5:0]  DFS_OFF_CMD      = 6'h04;
	localparam logic [5:0]  DFS_OFF_TEMP     = 6'h08;
	localparam logic [5:0]  DFS_OFF_VOLT     = 6'h0C;
	localparam logic [5:0]  DFS_OFF_EVENT    = 6'h10;
	// ----------------------------------------------------------------
	// status word bit positions
	// ----------------------------------------------------------------
	localparam int          DFS_B_HALT       = 0;
	localparam int          DFS_B_TEMP_WARN  = 1;
	localparam int          DFS_B_TEMP_ERR   = 2;
	localparam int          DFS_B_CUR_FAULT  = 3;
	localparam int          DFS_B_SUP_WARN   = 4;
	localparam int          DFS_B_SUP_FAULT  = 5;
	localparam int          DFS_B_ACK_REJ    = 6;
	localparam int          DFS_B_MOVE_DENY  = 7;
	// command register bits
	localparam int          DFS_C_ACK        = 0;
	localparam int          DFS_C_MOVE       = 1;
	// ----------------------------------------------------------------
	// thresholds: temperature in 0.1 degC, voltage in 10 mV
	// ----------------------------------------------------------------
	localparam logic [11:0] DFS_TEMP_WARN_TH = 12'h0_28A; // 65.0 degC
	localparam logic [11:0] DFS_TEMP_ERR_TH  = 12'h0_2BC; // 70.0 degC
	localparam logic [11:0] DFS_V_LO_FAULT   = 12'h0_7D0; // 20.00 V
	localparam logic [11:0] DFS_V_LO_WARN    = 12'h0_898; // 22.00 V
	localparam logic [11:0] DFS_V_HI_WARN    = 12'h0_A28; // 26.00 V
	localparam logic [11:0] DFS_V_HI_FAULT   = 12'h0_AF0; // 28.00 V
	localparam logic [11:0] DFS_V_HYST       = 12'h0_032; // 0.50 V
	// sync reset level inside the allowed band, so no false fault
	localparam logic [11:0] DFS_VOLT_RST     = 12'h0_960; // 24.00 V
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          DFS_CLK_MHZ      = 100;
	localparam int          DFS_BTN_HOLD_MS  = 5000;
	localparam longint      DFS_BTN_CYC      =
		longint'(DFS_BTN_HOLD_MS) * 1000 * DFS_CLK_MHZ;
	localparam int          DFS_BLINK_MS     = 250;
	localparam longint      DFS_BLINK_CYC    =
		longint'(DFS_BLINK_MS) * 1000 * DFS_CLK_MHZ;
	// supply zone and indicator codes
	typedef enum logic [1:0] {
		DFS_IND_OK,
		DFS_IND_WARN,
		DFS_IND_ERR
	} dfs_ind_t;
endpackage : dfs_pkg

// ### design/dfs_volt_zone.sv
// supply voltage classifier with hysteresis
`timescale 1ns/100ps
`default_nettype none
module dfs_volt_zone
	import dfs_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [DFS_VOLT_W-1:0] volt,
	input  wire logic                  supply_present,
	output logic                       warn,
	output logic                       fault,
	output logic                       in_range
);
	logic warn_reg;
	logic fault_reg;
	logic lo_f;
	logic hi_f;
	logic lo_w;
	logic hi_w;
	logic lo_f_clr;
	logic hi_f_clr;
	logic lo_w_clr;
	logic hi_w_clr;

	// set levels at thresholds, clear levels moved into the allowed band
	assign lo_f     = !supply_present || volt <= DFS_V_LO_FAULT;
	assign hi_f     = volt >= DFS_V_HI_FAULT;
	assign lo_w     = volt <= DFS_V_LO_WARN;
	assign hi_w     = volt >= DFS_V_HI_WARN;
	assign lo_f_clr = supply_present && volt > DFS_V_LO_FAULT + DFS_V_HYST;
	assign hi_f_clr = volt < DFS_V_HI_FAULT - DFS_V_HYST;
	assign lo_w_clr = volt > DFS_V_LO_WARN + DFS_V_HYST;
	assign hi_w_clr = volt < DFS_V_HI_WARN - DFS_V_HYST;

	// ----------------------------------------------------------------
	// zone flags, sticky inside the hysteresis band
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_reg <= 1'b0;
			warn_reg  <= 1'b0;
		end else begin
			if (lo_f || hi_f)
				fault_reg <= 1'b1;
			else if (lo_f_clr && hi_f_clr)
				fault_reg <= 1'b0;
			if (lo_w || hi_w)
				warn_reg <= 1'b1;
			else if (lo_w_clr && hi_w_clr)
				warn_reg <= 1'b0;
		end
	end

	assign fault    = fault_reg;
	assign warn     = warn_reg;
	assign in_range = !fault_reg;

	hyst_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(fault_reg && !lo_f && !hi_f && !(lo_f_clr && hi_f_clr))
		|=> fault_reg) else $error("fault left inside hysteresis band");
endmodule // dfs_volt_zone
`default_nettype wire

// ### design/dfs_supervisor.sv
// drive fault supervisor: thresholds, halt latch, axi4-lite slave
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module dfs_supervisor
	import dfs_pkg::*;
#(
	parameter longint BTN_CYC   = DFS_BTN_CYC,
	parameter longint BLINK_CYC = DFS_BLINK_CYC
)(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite slave
	input  wire logic [DFS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [DFS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// measurements and pins
	input  wire logic [DFS_TEMP_W-1:0] temp_in,
	input  wire logic [DFS_VOLT_W-1:0] volt_in,
	input  wire logic                  overload_in,
	input  wire logic                  supply_present_in,
	input  wire logic                  cfg_button_n,
	output logic                       power_stage_en,
	output logic                       position_ref_valid,
	output logic [1:0]                 status_indicator,
	output logic                       log_event,
	output logic [3:0]                 log_cause,
	output logic                       card_led,
	output logic                       factory_restore,
	output logic                       move_grant
);
	// counters are 40 bits wide; longer holds cannot be counted
	if (BTN_CYC < 1 || BLINK_CYC < 1 || BLINK_CYC > BTN_CYC ||
		BTN_CYC > 64'h0000_00FF_FFFF_FFFF) begin : g_bad_timing
		$error("dfs_supervisor: bad timing parameters");
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [DFS_TEMP_W-1:0] temp_s1_reg, temp_reg;
	logic [DFS_VOLT_W-1:0] volt_s1_reg, volt_reg;
	logic [2:0]            pin_s1_reg, pin_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_s1_reg <= '0;
			temp_reg    <= '0;
			volt_s1_reg <= DFS_VOLT_RST;
			volt_reg    <= DFS_VOLT_RST;
			pin_s1_reg  <= 3'h3;
			pin_reg     <= 3'h3;
		end else begin
			temp_s1_reg <= temp_in;
			temp_reg    <= temp_s1_reg;
			volt_s1_reg <= volt_in;
			volt_reg    <= volt_s1_reg;
			pin_s1_reg  <= {overload_in, supply_present_in, cfg_button_n};
			pin_reg     <= pin_s1_reg;
		end
	end

	logic overload;
	logic supply_ok;
	logic btn_held;
	assign overload  = pin_reg[2];
	assign supply_ok = pin_reg[1];
	assign btn_held  = !pin_reg[0];

	// ----------------------------------------------------------------
	// supply classification
	// ----------------------------------------------------------------
	logic sup_warn;
	logic sup_fault;
	logic sup_in_range;

	dfs_volt_zone u_zone (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.volt           (volt_reg),
		.supply_present (supply_ok),
		.warn           (sup_warn),
		.fault          (sup_fault),
		.in_range       (sup_in_range)
	);

	// ----------------------------------------------------------------
	// fault latches and halt
	// ----------------------------------------------------------------
	logic temp_warn;
	logic temp_hot;
	logic temp_err_reg;
	logic cur_fault_reg;
	logic volt_fault_reg;
	logic halt_reg;
	logic ack_rej_reg;
	logic ack_cmd;
	logic move_cmd;
	logic ack_ok;

	assign temp_warn = temp_reg > DFS_TEMP_WARN_TH;
	assign temp_hot  = temp_reg >= DFS_TEMP_ERR_TH;
	// acknowledge only when every active source has gone
	assign ack_ok    = !temp_hot && !overload && sup_in_range;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			temp_err_reg   <= 1'b0;
			cur_fault_reg  <= 1'b0;
			volt_fault_reg <= 1'b0;
			halt_reg       <= 1'b0;
			ack_rej_reg    <= 1'b0;
		end else begin
			// onsets win over an acknowledge in the same cycle
			if (ack_cmd && ack_ok) begin
				temp_err_reg   <= 1'b0;
				cur_fault_reg  <= 1'b0;
				volt_fault_reg <= 1'b0;
				halt_reg       <= 1'b0;
				ack_rej_reg    <= 1'b0;
			end else if (ack_cmd) begin
				ack_rej_reg <= 1'b1;
			end
			if (temp_hot) begin
				temp_err_reg <= 1'b1;
				halt_reg     <= 1'b1;
			end
			if (overload) begin
				cur_fault_reg <= 1'b1;
				halt_reg      <= 1'b1;
			end
			if (sup_fault) begin
				volt_fault_reg <= 1'b1;
				halt_reg       <= 1'b1;
			end
		end
	end

	// drive power off during halt; position reference kept
	assign power_stage_en     = !halt_reg;
	assign position_ref_valid = 1'b1;

	// ----------------------------------------------------------------
	// indicator and log events
	// ----------------------------------------------------------------
	logic [1:0] ind_reg;
	logic       twarn_d_reg;
	logic       thot_d_reg;
	logic       ovl_d_reg;
	logic       log_reg;
	logic [3:0] cause_reg;
	logic [3:0] onset;

	assign onset = {1'b0, overload && !ovl_d_reg,
		temp_hot && !thot_d_reg, temp_warn && !twarn_d_reg};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ind_reg     <= DFS_IND_OK;
			twarn_d_reg <= 1'b0;
			thot_d_reg  <= 1'b0;
			ovl_d_reg   <= 1'b0;
			log_reg     <= 1'b0;
			cause_reg   <= 4'h0;
		end else begin
			if (sup_fault)
				ind_reg <= DFS_IND_ERR;
			else if (sup_warn)
				ind_reg <= DFS_IND_WARN;
			else
				ind_reg <= DFS_IND_OK;
			twarn_d_reg <= temp_warn;
			thot_d_reg  <= temp_hot;
			ovl_d_reg   <= overload;
			log_reg     <= |onset;
			cause_reg   <= onset;
		end
	end

	assign status_indicator = ind_reg;
	assign log_event        = log_reg;
	assign log_cause        = cause_reg;

	// ----------------------------------------------------------------
	// configuration reset button
	// ----------------------------------------------------------------
	logic [39:0] btn_cnt_reg;
	logic [39:0] blink_cnt_reg;
	logic        led_reg;
	logic        restore_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			btn_cnt_reg   <= '0;
			blink_cnt_reg <= '0;
			led_reg       <= 1'b0;
			restore_reg   <= 1'b0;
		end else begin
			restore_reg <= 1'b0;
			if (!btn_held) begin
				btn_cnt_reg   <= '0;
				blink_cnt_reg <= '0;
				led_reg       <= 1'b0;
			end else begin
				if (btn_cnt_reg == 40'(BTN_CYC - 1))
					restore_reg <= 1'b1;
				if (btn_cnt_reg != 40'(BTN_CYC))
					btn_cnt_reg <= btn_cnt_reg + 40'h1;
				if (blink_cnt_reg == 40'(BLINK_CYC - 1)) begin
					blink_cnt_reg <= '0;
					led_reg       <= !led_reg;
				end else begin
					blink_cnt_reg <= blink_cnt_reg + 40'h1;
				end
			end
		end
	end

	assign card_led        = led_reg;
	assign factory_restore = restore_reg;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	logic [DFS_ADDR_W-1:0] aw_reg;
	logic                  aw_have_reg;
	logic [31:0]           w_reg;
	logic                  w_have_reg;
	logic                  bvalid_reg;
	logic [1:0]            bresp_reg;
	logic                  rvalid_reg;
	logic [31:0]           rdata_reg;
	logic [1:0]            rresp_reg;
	logic                  deny_reg;
	logic                  grant_reg;
	logic                  do_wr;
	logic [31:0]           status_word;

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_wr         = aw_have_reg && w_have_reg && !bvalid_reg;
	assign ack_cmd  = do_wr && aw_reg == DFS_OFF_CMD && w_reg[DFS_C_ACK];
	assign move_cmd = do_wr && aw_reg == DFS_OFF_CMD && w_reg[DFS_C_MOVE];

	always_comb begin
		status_word                  = '0;
		status_word[DFS_B_HALT]      = halt_reg;
		status_word[DFS_B_TEMP_WARN] = temp_warn;
		status_word[DFS_B_TEMP_ERR]  = temp_err_reg;
		status_word[DFS_B_CUR_FAULT] = cur_fault_reg;
		status_word[DFS_B_SUP_WARN]  = sup_warn;
		status_word[DFS_B_SUP_FAULT] = volt_fault_reg;
		status_word[DFS_B_ACK_REJ]   = ack_rej_reg;
		status_word[DFS_B_MOVE_DENY] = deny_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_reg      <= '0;
			w_reg       <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			deny_reg    <= 1'b0;
			grant_reg   <= 1'b0;
		end else begin
			grant_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_reg      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_reg      <= s_axi_wdata & {{8{s_axi_wstrb[3]}},
					{8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
					{8{s_axi_wstrb[0]}}};
			end
			if (do_wr) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (aw_reg == DFS_OFF_CMD) ? 2'h0 : 2'h2;
				if (move_cmd) begin
					deny_reg  <= halt_reg;
					grant_reg <= !halt_reg;
				end
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= 2'h0;
			case (s_axi_araddr)
				DFS_OFF_STATUS: rdata_reg <= status_word;
				DFS_OFF_CMD:    rdata_reg <= '0;
				DFS_OFF_TEMP:   rdata_reg <= {20'h0_0000, temp_reg};
				DFS_OFF_VOLT:   rdata_reg <= {20'h0_0000, volt_reg};
				DFS_OFF_EVENT:  rdata_reg <= {28'h000_0000, cause_reg};
				default: begin
					rdata_reg <= '0;
					rresp_reg <= 2'h2;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;
	assign move_grant   = grant_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	halt_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
		halt_reg |-> !power_stage_en) else $error("power on in halt");
	temp_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
		temp_hot |=> halt_reg && temp_err_reg) else $error("no temp halt");
	temp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		temp_err_reg && !ack_cmd |=> temp_err_reg) else $error("temp cleared");
	ack_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ack_cmd && (temp_hot || overload) |=> halt_reg) else $error("ack taken");
	cur_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		overload |=> cur_fault_reg && halt_reg) else $error("no cur fault");
	volt_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ack_cmd && !sup_in_range |=> volt_fault_reg) else $error("volt ack");
	log_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(overload) |=> log_event ##1 !log_event || $rose(overload))
		else $error("no log pulse");
	move_deny_a: assert property (@(posedge aclk) disable iff (!aresetn)
		move_cmd && halt_reg |=> deny_reg && !move_grant)
		else $error("move in halt");
	ind_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
		sup_fault |=> status_indicator == DFS_IND_ERR) else $error("ind");
endmodule // dfs_supervisor
`default_nettype wire

// ### test/dfs_host_model.sv
// host-side axi4-lite master that issues commands and reads status
`timescale 1ns/100ps
`default_nettype none
module dfs_host_model
	import dfs_pkg::*;
(
	input  wire logic                  aclk,
	output logic [DFS_ADDR_W-1:0]      s_axi_awaddr,
	output logic                       s_axi_awvalid,
	input  wire logic                  s_axi_awready,
	output logic [31:0]                s_axi_wdata,
	output logic [3:0]                 s_axi_wstrb,
	output logic                       s_axi_wvalid,
	input  wire logic                  s_axi_wready,
	input  wire logic [1:0]            s_axi_bresp,
	input  wire logic                  s_axi_bvalid,
	output logic                       s_axi_bready,
	output logic [DFS_ADDR_W-1:0]      s_axi_araddr,
	output logic                       s_axi_arvalid,
	input  wire logic                  s_axi_arready,
	input  wire logic [31:0]           s_axi_rdata,
	input  wire logic [1:0]            s_axi_rresp,
	input  wire logic                  s_axi_rvalid,
	output logic                       s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
	end
	// ----------------------------------------------------------------
	// write: also carries the halt acknowledge command
	// ----------------------------------------------------------------
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	// ----------------------------------------------------------------
	// read
	// ----------------------------------------------------------------
	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
endmodule // dfs_host_model
`default_nettype wire

// ### test/test_dfs_supervisor.sv
// self-checking bench for the drive fault supervisor
`timescale 1ns/100ps
`default_nettype none
module test_dfs_supervisor;
	import dfs_pkg::*;
	localparam logic [31:0] HLT = 32'h0000_0001 << DFS_B_HALT;
	localparam logic [31:0] TE  = 32'h0000_0001 << DFS_B_TEMP_ERR;
	localparam logic [31:0] CF  = 32'h0000_0001 << DFS_B_CUR_FAULT;
	localparam logic [31:0] SF  = 32'h0000_0001 << DFS_B_SUP_FAULT;
	localparam logic [31:0] AR  = 32'h0000_0001 << DFS_B_ACK_REJ;
	localparam logic [31:0] MD  = 32'h0000_0001 << DFS_B_MOVE_DENY;
	localparam logic [31:0] ACK = 32'h0000_0001 << DFS_C_ACK;
	localparam logic [31:0] MOV = 32'h0000_0001 << DFS_C_MOVE;
	typedef struct packed {
		logic [11:0] t;
		logic [11:0] v;
		logic [7:0]  st;
		logic [1:0]  ind;
	} dfs_row_t;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, log_cause;
	logic [1:0] s_axi_bresp, s_axi_rresp, status_indicator, rsp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, power_stage_en, position_ref_valid;
	logic log_event, card_led, factory_restore, move_grant, led_q = 1'b0;
	logic [11:0] temp_in = 12'h0_0FA, volt_in = 12'h0_960;
	logic overload_in = 1'b0, supply_present_in = 1'b1, cfg_button_n = 1'b1;
	logic [3:0] log_acc = '0;
	logic [31:0] rdv;
	int miscompares = 0, total_checks = 0, grants = 0, restores = 0;
	int toggles = 0;
	dfs_row_t rows[12] = '{
		'{12'h0_0FA, 12'h0_960, 8'h00, 2'd0}, '{12'h0_0FA, 12'h0_899, 8'h00, 2'd0},
		'{12'h0_0FA, 12'h0_898, 8'h10, 2'd1}, '{12'h0_0FA, 12'h0_8AC, 8'h10, 2'd1},
		'{12'h0_0FA, 12'h0_960, 8'h00, 2'd0}, '{12'h0_0FA, 12'h0_A27, 8'h00, 2'd0},
		'{12'h0_0FA, 12'h0_A28, 8'h10, 2'd1}, '{12'h0_0FA, 12'h0_A14, 8'h10, 2'd1},
		'{12'h0_0FA, 12'h0_960, 8'h00, 2'd0}, '{12'h0_28A, 12'h0_960, 8'h00, 2'd0},
		'{12'h0_28B, 12'h0_960, 8'h02, 2'd0}, '{12'h0_0FA, 12'h0_960, 8'h00, 2'd0}};
	logic [11:0] fv[3] = '{12'h0_7D0, 12'h0_AF0, 12'h0_960};
	logic        fp[3] = '{1'b1, 1'b1, 1'b0};

	initial forever #5 aclk = ~aclk;

	dfs_supervisor #(.BTN_CYC(40), .BLINK_CYC(8)) dfs_supervisor_inst (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .temp_in, .volt_in, .overload_in,
		.supply_present_in, .cfg_button_n, .power_stage_en,
		.position_ref_valid, .status_indicator, .log_event, .log_cause,
		.card_led, .factory_restore, .move_grant);
	dfs_host_model dfs_host_model_inst (
		.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	// pulse counters: outputs stand one cycle, so count every edge
	always @(posedge aclk) begin
		if (move_grant === 1'b1) grants++;
		if (factory_restore === 1'b1) restores++;
		if (log_event === 1'b1) log_acc = log_acc | log_cause;
		if (card_led !== led_q) toggles++;
		led_q = card_led;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic settle(input logic [11:0] t, v, input logic o, p);
		@(posedge aclk);
		temp_in <= t;
		volt_in <= v;
		overload_in <= o;
		supply_present_in <= p;
		repeat (8) @(posedge aclk);
	endtask
	task automatic stat(input logic [31:0] m, e, input string n);
		dfs_host_model_inst.rd(DFS_OFF_STATUS, rdv, rsp);
		check(n, rdv & m, e);
	endtask
	task automatic cmd(input logic [31:0] c);
		dfs_host_model_inst.wr(DFS_OFF_CMD, c, rsp);
		check("cmd_resp", 32'(rsp), 32'h0000_0000);
		repeat (3) @(posedge aclk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// watchdog: whole run is well under 3000 cycles
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		print_verdict;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		check("power_rst", 32'(power_stage_en), 32'h0000_0001);
		check("posref", 32'(position_ref_valid), 32'h0000_0001);
		foreach (rows[i]) begin
			settle(rows[i].t, rows[i].v, 1'b0, 1'b1);
			stat(32'h0000_003F, 32'(rows[i].st), "row");
			if (!rows[i].st[1])
				check("ind", 32'(status_indicator), 32'(rows[i].ind));
		end
		check("log_warn", 32'(log_acc), 32'h0000_0001);
		dfs_host_model_inst.rd(DFS_OFF_TEMP, rdv, rsp);
		check("temp_rd", rdv, 32'h0000_00FA);
		dfs_host_model_inst.rd(DFS_OFF_VOLT, rdv, rsp);
		check("volt_rd", rdv, 32'h0000_0960);
		settle(12'h0_2BC, 12'h0_960, 1'b0, 1'b1);
		check("power_te", 32'(power_stage_en), 32'h0000_0000);
		check("log_te", 32'(log_acc[1]), 32'h0000_0001);
		stat(HLT | TE, HLT | TE, "te");
		cmd(MOV);
		stat(MD, MD, "deny");
		check("no_grant", 32'(grants), 32'h0000_0000);
		check("posref_h", 32'(position_ref_valid), 32'h0000_0001);
		cmd(ACK);
		stat(HLT | TE | AR, HLT | TE | AR, "te_rej");
		settle(12'h0_294, 12'h0_960, 1'b0, 1'b1);
		stat(HLT | TE, HLT | TE, "te_held");
		cmd(ACK);
		stat(HLT | TE, 32'h0000_0000, "te_ack");
		cmd(MOV);
		check("grant", 32'(grants), 32'h0000_0001);
		settle(12'h0_0FA, 12'h0_960, 1'b1, 1'b1);
		check("power_cf", 32'(power_stage_en), 32'h0000_0000);
		check("log_cf", 32'(log_acc[2]), 32'h0000_0001);
		cmd(ACK);
		stat(HLT | CF | AR, HLT | CF | AR, "cf_rej");
		settle(12'h0_0FA, 12'h0_960, 1'b0, 1'b1);
		stat(HLT | CF, HLT | CF, "cf_held");
		cmd(ACK);
		stat(HLT | CF, 32'h0000_0000, "cf_ack");
		for (int i = 0; i < 3; i++) begin
			settle(12'h0_0FA, fv[i], 1'b0, fp[i]);
			check("power_sf", 32'(power_stage_en), 32'h0000_0000);
			check("ind_sf", 32'(status_indicator), 32'h0000_0002);
			stat(HLT | SF, HLT | SF, "sf");
			cmd(ACK);
			stat(HLT | AR, HLT | AR, "sf_rej");
			settle(12'h0_0FA, 12'h0_960, 1'b0, 1'b1);
			cmd(ACK);
			stat(HLT, 32'h0000_0000, "sf_ack");
			check("power_ok", 32'(power_stage_en), 32'h0000_0001);
		end
		// reset in mid-run while halted clears every latch
		settle(12'h0_0FA, 12'h0_960, 1'b1, 1'b1);
		check("power_pre", 32'(power_stage_en), 32'h0000_0000);
		overload_in <= 1'b0;
		aresetn     <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check("power_rst2", 32'(power_stage_en), 32'h0000_0001);
		check("ind_rst2", 32'(status_indicator), 32'h0000_0000);
		stat(32'h0000_00FF, 32'h0000_0000, "rst2");
		dfs_host_model_inst.rd(6'h3C, rdv, rsp);
		check("unm_resp", 32'(rsp), 32'h0000_0002);
		check("unm_data", rdv, 32'h0000_0000);
		dfs_host_model_inst.wr(DFS_OFF_STATUS, 32'h0000_0001, rsp);
		check("ro_resp", 32'(rsp), 32'h0000_0002);
		@(posedge aclk);
		cfg_button_n <= 1'b0;
		repeat (60) @(posedge aclk);
		cfg_button_n <= 1'b1;
		repeat (4) @(posedge aclk);
		check("restore", 32'(restores), 32'h0000_0001);
		check("blink", 32'(toggles > 2), 32'h0000_0001);
		print_verdict;
	end
endmodule // test_dfs_supervisor
`default_nettype wire
